// [branch_bit_core.v]
// Branch, bit manipulation and exchange execution unit of the 8-bit core
// Operation
// - Exchange via pointer register: one byte, two cycles
// - AND/OR bit or complement into carry
// - Move bit to carry, carry to bit
// - Carry jumps: two bytes, 2 or 4
// - Bit-test jumps: three bytes, 3 or 5
// - Jump-if-set also clears the tested bit
// - Absolute call/jump: 11-bit field, same page, 4
// - Long call/jump: 16-bit target, 5 cycles
// - Relative target is next address plus offset
// - Indirect jump to accumulator plus data pointer
// - Accumulator zero jumps: 2 or 4 cycles
// - Compare-and-jump: 3/5, indirect form 4/6
// - Decrement-and-jump: register 2/4, direct 3/5
// - Opcode A5 behaves as no-operation
// - Direct below 0x80 is RAM, above SFR
// - Pointers from R0/R1; registers in selected bank
// - Program and data spaces kept separate
// - 64k program space; top area reserved
// - External writes go to program store when enabled
// - Clear, set, complement bit: two cycles
`timescale 1ns/1ns
`include "core_defs.vh"
module branch_bit_core #(
    parameter FLASH_64K = 1
) (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    input wire clk_en,
    // Program memory fetch: bytes at pc, pc+1 and pc+2
    output reg [15:0] pc,
    input wire [7:0] code_b0,
    input wire [7:0] code_b1,
    input wire [7:0] code_b2,
    // Data RAM and SFR space
    output reg [7:0] mem_addr,
    output reg mem_sfr,
    output reg mem_we,
    output reg [7:0] mem_wdata,
    input wire [7:0] mem_rdata,
    // Core state held in the SFR block
    input wire [1:0] bank_select,
    input wire [15:0] data_pointer,
    input wire [7:0] program_store_control,
    // External data and program store writes
    output reg [15:0] ext_addr,
    output reg [7:0] ext_wdata,
    output reg xdata_we,
    output reg code_we,
    // Status
    output reg [7:0] acc,
    output reg carry,
    output reg [7:0] sp,
    output reg insn_done,
    output reg unsupported_op,
    output reg pc_reserved
);

// ----------------------------------------
// State
// ----------------------------------------
reg [7:0] regfile [0:31];
reg [2:0] cnt;
reg [2:0] last;
reg [7:0] op;
reg [7:0] opa;
reg [2:0] bpos;
reg [15:0] npc;
reg [15:0] jtgt;
reg tk;
reg condq;
integer i;

// ----------------------------------------
// Decode of the byte at pc
// ----------------------------------------
reg [1:0] len;
reg [2:0] cyc;
reg uncond;
reg cond;
reg unsup;
reg [7:0] raddr;
reg rsfr;
reg [7:0] rel8;
reg [15:0] next_jtgt;
wire [7:0] bl_byte;
wire bl_sfr;
wire [2:0] bl_pos;
wire [15:0] seq_pc = pc + {14'h0000, len};
wire [7:0] ri_val = regfile[{bank_select, 2'b00, code_b0[0]}];

bit_locator u_bit_locator (
    .bit_addr(code_b1),
    .byte_addr(bl_byte),
    .is_sfr(bl_sfr),
    .bit_pos(bl_pos)
);

always @* begin
    len = 2'd1;
    cyc = `CYC_ONE;
    uncond = 1'b0;
    cond = 1'b0;
    unsup = 1'b0;
    raddr = code_b1;
    rsfr = code_b1[7];
    casez (code_b0)
        `OP_NOP, `OP_SPARE, `OP_CLR_C, `OP_SETB_C, `OP_CPL_C: begin
            cyc = `CYC_ONE;
        end
        `OP_CLR_BIT, `OP_SETB_BIT, `OP_CPL_BIT, `OP_ANL_C, `OP_ANL_NC,
        `OP_ORL_C, `OP_ORL_NC, `OP_MOV_CB, `OP_MOV_BC: begin
            len = 2'd2;
            cyc = `CYC_BIT;
            raddr = bl_byte;
            rsfr = bl_sfr;
        end
        `OP_JC, `OP_JNC, `OP_JZ, `OP_JNZ: begin
            len = 2'd2;
            cyc = `CYC_JREL;
            cond = 1'b1;
        end
        `OP_JB, `OP_JNB, `OP_JBC: begin
            len = 2'd3;
            cyc = `CYC_JBIT;
            cond = 1'b1;
            raddr = bl_byte;
            rsfr = bl_sfr;
        end
        `OP_LJMP, `OP_LCALL: begin
            len = 2'd3;
            cyc = `CYC_LONG;
            uncond = 1'b1;
        end
        `OP_RET, `OP_RETI: begin
            cyc = `CYC_RET;
            uncond = 1'b1;
            raddr = sp;
            rsfr = 1'b0;
        end
        `OP_SJMP: begin
            len = 2'd2;
            cyc = `CYC_SJMP;
            uncond = 1'b1;
        end
        `OP_JMP_IND: begin
            cyc = `CYC_JIND;
            uncond = 1'b1;
        end
        `OP_CJNE_AI, `OP_CJNE_AD: begin
            len = 2'd3;
            cyc = `CYC_JBIT;
            cond = 1'b1;
        end
        `OP_CJNE_IR: begin
            len = 2'd3;
            cyc = `CYC_CJI;
            cond = 1'b1;
            raddr = ri_val;
            rsfr = 1'b0;
        end
        `OP_CJNE_RN: begin
            len = 2'd3;
            cyc = `CYC_JBIT;
            cond = 1'b1;
            raddr = {3'b000, bank_select, code_b0[2:0]};
            rsfr = 1'b0;
        end
        `OP_DJNZ_RN: begin
            len = 2'd2;
            cyc = `CYC_JREL;
            cond = 1'b1;
            raddr = {3'b000, bank_select, code_b0[2:0]};
            rsfr = 1'b0;
        end
        `OP_DJNZ_D: begin
            len = 2'd3;
            cyc = `CYC_JBIT;
            cond = 1'b1;
        end
        `OP_XCH_IR, `OP_XCHD_IR: begin
            cyc = `CYC_BIT;
            raddr = ri_val;
            rsfr = 1'b0;
        end
        `OP_MOVX_DP, `OP_MOVX_RI: begin
            cyc = `CYC_MOVX;
        end
        `OP_AJMP, `OP_ACALL: begin
            len = 2'd2;
            cyc = `CYC_ABS;
            uncond = 1'b1;
        end
        default: begin
            unsup = 1'b1;
        end
    endcase
    rel8 = (len == 2'd2) ? code_b1 : code_b2;
    casez (code_b0)
        `OP_LJMP, `OP_LCALL: next_jtgt = {code_b1, code_b2};
        `OP_JMP_IND: next_jtgt = data_pointer + {8'h00, acc};
        `OP_AJMP, `OP_ACALL: next_jtgt = {seq_pc[15:11], code_b0[7:5], code_b1};
        default: next_jtgt = seq_pc + {{8{rel8[7]}}, rel8};
    endcase
end

// ----------------------------------------
// Execute: operand read and branch decision
// ----------------------------------------
// Registers R0-R7 of all banks live here so pointer values are ready at decode
wire internal = ~mem_sfr & (mem_addr[7:5] == 3'b000);
wire [7:0] rd = internal ? regfile[mem_addr[4:0]] : mem_rdata;
wire bitv = rd[bpos];
wire [7:0] rd_dec = rd - 8'h01;
wire [7:0] bit_mask = 8'h01 << bpos;
wire [7:0] bit_set = rd | bit_mask;
wire [7:0] bit_clr = rd & ~bit_mask;
reg take;
reg cj_lt;

always @* begin
    take = 1'b0;
    cj_lt = 1'b0;
    casez (op)
        `OP_JC: take = carry;
        `OP_JNC: take = ~carry;
        `OP_JZ: take = (acc == 8'h00);
        `OP_JNZ: take = (acc != 8'h00);
        `OP_JB, `OP_JBC: take = bitv;
        `OP_JNB: take = ~bitv;
        `OP_CJNE_AI: begin
            take = (acc != opa);
            cj_lt = (acc < opa);
        end
        `OP_CJNE_AD: begin
            take = (acc != rd);
            cj_lt = (acc < rd);
        end
        `OP_CJNE_IR, `OP_CJNE_RN: begin
            take = (rd != opa);
            cj_lt = (rd < opa);
        end
        `OP_DJNZ_RN, `OP_DJNZ_D: take = (rd_dec != 8'h00);
        default: take = 1'b0;
    endcase
end

// A taken conditional branch stretches the instruction by two clocks, decided in its second cycle
wire extend = (cnt == 3'd1) & condq & take;
wire finish = (cnt == last) & ~extend;

// Byte store: the register banks are written here, everything else goes out one cycle later
task store;
    input [7:0] a;
    input s;
    input [7:0] d;
    begin
        if (!s && a[7:5] == 3'b000) begin
            regfile[a[4:0]] <= d;
        end else begin
            mem_addr <= a;
            mem_sfr <= s;
            mem_wdata <= d;
            mem_we <= 1'b1;
        end
    end
endtask

// ----------------------------------------
// Sequencer
// ----------------------------------------
always @(posedge mclk) begin
    if (sys_rst) begin
        pc <= `PC_RESET;
        sp <= `SP_RESET;
        acc <= 8'h00;
        carry <= 1'b0;
        cnt <= 3'd0;
        last <= 3'd0;
        op <= 8'h00;
        opa <= 8'h00;
        bpos <= 3'd0;
        npc <= 16'h0000;
        jtgt <= 16'h0000;
        tk <= 1'b0;
        condq <= 1'b0;
        mem_addr <= 8'h00;
        mem_sfr <= 1'b0;
        mem_we <= 1'b0;
        mem_wdata <= 8'h00;
        ext_addr <= 16'h0000;
        ext_wdata <= 8'h00;
        xdata_we <= 1'b0;
        code_we <= 1'b0;
        insn_done <= 1'b0;
        unsupported_op <= 1'b0;
        pc_reserved <= 1'b0;
        for (i = 0; i < 32; i = i + 1) begin
            regfile[i] <= 8'h00;
        end
    end else if (clk_en) begin
        mem_we <= 1'b0;
        xdata_we <= 1'b0;
        code_we <= 1'b0;
        insn_done <= 1'b0;
        unsupported_op <= 1'b0;
        pc_reserved <= 1'b0;
        if (cnt == 3'd0) begin
            // Fetch bytes arrive with pc, so decode costs no extra clock
            op <= code_b0;
            opa <= code_b1;
            bpos <= bl_pos;
            npc <= seq_pc;
            jtgt <= next_jtgt;
            tk <= uncond;
            condq <= cond;
            mem_addr <= raddr;
            mem_sfr <= rsfr;
            last <= cyc - 3'd1;
            pc_reserved <= (FLASH_64K != 0) && (pc > `PC_TOP_64K);
            case (code_b0)
                `OP_CLR_C: carry <= 1'b0;
                `OP_SETB_C: carry <= 1'b1;
                `OP_CPL_C: carry <= ~carry;
                default: carry <= carry;
            endcase
            if (cyc == `CYC_ONE) begin
                pc <= seq_pc;
                insn_done <= 1'b1;
                unsupported_op <= unsup;
            end else begin
                cnt <= 3'd1;
            end
        end else begin
            if (cnt == 3'd1) begin
                if (condq) begin
                    tk <= take;
                end
                casez (op)
                    `OP_CLR_BIT: store(mem_addr, mem_sfr, bit_clr);
                    `OP_SETB_BIT: store(mem_addr, mem_sfr, bit_set);
                    `OP_CPL_BIT: store(mem_addr, mem_sfr, bitv ? bit_clr : bit_set);
                    `OP_ANL_C: carry <= carry & bitv;
                    `OP_ANL_NC: carry <= carry & ~bitv;
                    `OP_ORL_C: carry <= carry | bitv;
                    `OP_ORL_NC: carry <= carry | ~bitv;
                    `OP_MOV_CB: carry <= bitv;
                    `OP_MOV_BC: store(mem_addr, mem_sfr, carry ? bit_set : bit_clr);
                    `OP_JBC: begin
                        if (bitv) begin
                            store(mem_addr, mem_sfr, bit_clr);
                        end
                    end
                    `OP_CJNE_AI, `OP_CJNE_AD, `OP_CJNE_IR, `OP_CJNE_RN: carry <= cj_lt;
                    `OP_DJNZ_RN, `OP_DJNZ_D: store(mem_addr, mem_sfr, rd_dec);
                    `OP_XCH_IR: begin
                        acc <= rd;
                        store(mem_addr, 1'b0, acc);
                    end
                    `OP_XCHD_IR: begin
                        acc <= {acc[7:4], rd[3:0]};
                        store(mem_addr, 1'b0, {rd[7:4], acc[3:0]});
                    end
                    `OP_MOVX_DP, `OP_MOVX_RI: begin
                        // External-data writes land in program store while enabled
                        if (op[1]) begin
                            ext_addr <= {8'h00, regfile[{bank_select, 2'b00, op[0]}]};
                        end else begin
                            ext_addr <= data_pointer;
                        end
                        ext_wdata <= acc;
                        code_we <= program_store_control[`PSC_WEN_BIT];
                        xdata_we <= ~program_store_control[`PSC_WEN_BIT];
                    end
                    `OP_LCALL, `OP_ACALL: store(sp + 8'h01, 1'b0, npc[7:0]);
                    `OP_RET, `OP_RETI: begin
                        jtgt[15:8] <= rd;
                        mem_addr <= sp - 8'h01;
                        mem_sfr <= 1'b0;
                    end
                    default: carry <= carry;
                endcase
            end
            if (cnt == 3'd2) begin
                casez (op)
                    `OP_LCALL, `OP_ACALL: begin
                        store(sp + 8'h02, 1'b0, npc[15:8]);
                        sp <= sp + 8'h02;
                    end
                    `OP_RET, `OP_RETI: begin
                        jtgt[7:0] <= rd;
                        sp <= sp - 8'h02;
                    end
                    default: sp <= sp;
                endcase
            end
            if (extend) begin
                last <= last + `CYC_TAKEN_EXTRA;
            end
            if (finish) begin
                pc <= tk ? jtgt : npc;
                cnt <= 3'd0;
                insn_done <= 1'b1;
            end else begin
                cnt <= cnt + 3'd1;
            end
        end
    end
end

endmodule

// [core_defs.vh]
// Opcodes, reset values, field positions and cycle counts of the branch and bit core
`ifndef CORE_DEFS_VH
`define CORE_DEFS_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_NOP 8'h00
`define OP_SPARE 8'hA5
`define OP_CLR_C 8'hC3
`define OP_SETB_C 8'hD3
`define OP_CPL_C 8'hB3
`define OP_CLR_BIT 8'hC2
`define OP_SETB_BIT 8'hD2
`define OP_CPL_BIT 8'hB2
`define OP_ANL_C 8'h82
`define OP_ANL_NC 8'hB0
`define OP_ORL_C 8'h72
`define OP_ORL_NC 8'hA0
`define OP_MOV_CB 8'hA2
`define OP_MOV_BC 8'h92
`define OP_JC 8'h40
`define OP_JNC 8'h50
`define OP_JZ 8'h60
`define OP_JNZ 8'h70
`define OP_JB 8'h20
`define OP_JNB 8'h30
`define OP_JBC 8'h10
`define OP_AJMP 8'b???0_0001
`define OP_ACALL 8'b???1_0001
`define OP_LJMP 8'h02
`define OP_LCALL 8'h12
`define OP_RET 8'h22
`define OP_RETI 8'h32
`define OP_SJMP 8'h80
`define OP_JMP_IND 8'h73
`define OP_CJNE_AI 8'hB4
`define OP_CJNE_AD 8'hB5
`define OP_CJNE_IR 8'b1011_011?
`define OP_CJNE_RN 8'b1011_1???
`define OP_DJNZ_RN 8'b1101_1???
`define OP_DJNZ_D 8'hD5
`define OP_XCH_IR 8'b1100_011?
`define OP_XCHD_IR 8'b1101_011?
`define OP_MOVX_DP 8'hF0
`define OP_MOVX_RI 8'b1111_001?

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define PC_RESET 16'h0000
`define SP_RESET 8'h07
`define PC_TOP_64K 16'hFBFF
`define PSC_WEN_BIT 0
`define RAM_BIT_BASE 8'h20

// ----------------------------------------
// Cycle counts in system clock periods
// ----------------------------------------
`define CYC_ONE 3'd1
`define CYC_BIT 3'd2
`define CYC_JREL 3'd2
`define CYC_JBIT 3'd3
`define CYC_CJI 3'd4
`define CYC_ABS 3'd4
`define CYC_SJMP 3'd4
`define CYC_JIND 3'd4
`define CYC_LONG 3'd5
`define CYC_RET 3'd6
`define CYC_MOVX 3'd3
`define CYC_TAKEN_EXTRA 3'd2

`endif

// [bit_locator.v]
// Maps a direct bit address onto its byte address, space and bit position
`timescale 1ns/1ns
`include "core_defs.vh"
module bit_locator (
    // Bit address
    input wire [7:0] bit_addr,
    // Located byte
    output wire [7:0] byte_addr,
    output wire is_sfr,
    output wire [2:0] bit_pos
);

// Low half maps into the bit-addressable RAM bytes, high half onto SFRs ending in 0 or 8
assign is_sfr = bit_addr[7];
assign byte_addr = is_sfr ? {bit_addr[7:3], 3'b000} : (`RAM_BIT_BASE | {4'h0, bit_addr[6:3]});
assign bit_pos = bit_addr[2:0];

endmodule

// [branch_bit_core_properties.sv]
// Port checks for the branch and bit core
`timescale 1ns/1ns
`include "core_defs.vh"
module branch_bit_core_properties (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    input wire clk_en,
    // Fetch
    input wire [15:0] pc,
    input wire [7:0] code_b0,
    input wire [7:0] code_b1,
    input wire [7:0] code_b2,
    // Data and external writes
    input wire [7:0] mem_addr,
    input wire mem_sfr,
    input wire mem_we,
    input wire [7:0] mem_wdata,
    input wire [7:0] mem_rdata,
    input wire [7:0] program_store_control,
    input wire xdata_we,
    input wire code_we,
    // Status
    input wire carry,
    input wire insn_done
);
    // ----
    // Helpers
    // ----
    reg was_rst;
    always @(posedge mclk) begin
        was_rst <= sys_rst;
    end
    // Cycle 0 of an instruction: just after reset or a completion
    wire start = (insn_done | was_rst) & clk_en;
    wire [15:0] next2 = pc + 16'd2;
    wire [15:0] rel_tgt = next2 + {{8{code_b1[7]}}, code_b1};
    wire [15:0] abs_tgt = {next2[15:11], code_b0[7:5], code_b1};
    wire [15:0] long_tgt = {code_b1, code_b2};
    wire bit_sfr = code_b1[7];
    wire [7:0] bit_byte = bit_sfr ? {code_b1[7:3], 3'b000} : 8'h20 + {4'h0, code_b1[6:3]};
    wire [7:0] bit_mask = 8'h01 << code_b1[2:0];
    wire store_en = program_store_control[0];
    wire bit_op = code_b0 == `OP_SETB_BIT || code_b0 == `OP_CLR_BIT || code_b0 == `OP_CPL_BIT;
    wire carry_op = code_b0 == `OP_ANL_C || code_b0 == `OP_ANL_NC || code_b0 == `OP_ORL_C
        || code_b0 == `OP_ORL_NC || code_b0 == `OP_MOV_CB || code_b0 == `OP_MOV_BC;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_busy3;
        !insn_done [*3];
    endsequence
    sequence s_busy4;
        !insn_done [*4];
    endsequence
    // ----
    // Assertions
    // ----
    a_spare_nop:
    assert property (start && (code_b0 == `OP_SPARE || code_b0 == `OP_NOP)
        |=> insn_done && pc == $past(pc) + 16'd1) else $error("spare opcode not a skip");
    a_rel_taken:
    assert property (start && ((code_b0 == `OP_JC && carry) || (code_b0 == `OP_JNC && !carry)
        || code_b0 == `OP_SJMP) |=> s_busy3 ##1 (insn_done && pc == $past(rel_tgt, 4)))
        else $error("taken relative jump wrong");
    a_rel_fall:
    assert property (start && ((code_b0 == `OP_JC && !carry) || (code_b0 == `OP_JNC && carry))
        |=> !insn_done ##1 (insn_done && pc == $past(pc, 2) + 16'd2))
        else $error("untaken jump wrong");
    a_abs_page:
    assert property (start && code_b0[3:0] == 4'h1 |=> s_busy3 ##1 (insn_done
        && pc == $past(abs_tgt, 4))) else $error("absolute target wrong");
    a_long_jump:
    assert property (start && (code_b0 == `OP_LJMP || code_b0 == `OP_LCALL)
        |=> s_busy4 ##1 (insn_done && pc == $past(long_tgt, 5))) else $error("long target wrong");
    a_bit_byte:
    assert property (start && bit_op |=> mem_addr == $past(bit_byte)
        && mem_sfr == $past(bit_sfr)) else $error("bit byte address wrong");
    a_setb_write:
    assert property (start && code_b0 == `OP_SETB_BIT |=> ##1 mem_we
        && mem_wdata == ($past(mem_rdata) | $past(bit_mask, 2))) else $error("bit set write wrong");
    a_carry_two:
    assert property (start && carry_op |=> !insn_done ##1 insn_done)
        else $error("carry bit op length wrong");
    a_strobe_excl:
    assert property (!(xdata_we && code_we)) else $error("both write strobes high");
    a_store_on:
    assert property (code_we |-> $past(store_en)) else $error("program store write not enabled");
    a_xdata_off:
    assert property (xdata_we |-> !$past(store_en)) else $error("external write while enabled");
endmodule

// [branch_bit_core_test.sv]
// Self-checking bench for the branch and bit core
`timescale 1ns/1ns
`include "core_defs.vh"
module branch_bit_core_test;
    // ----
    // Signals and model state
    // ----
    typedef struct {logic [15:0] pc; integer cyc; logic c; logic [7:0] a; logic u;} exp_t;
    reg mclk = 1'b0;
    reg sys_rst = 1'b1;
    reg [7:0] program_store_control = 8'h00;
    reg [15:0] data_pointer;
    wire [15:0] pc, ext_addr;
    wire [7:0] mem_addr, mem_wdata, ext_wdata, acc, sp;
    wire mem_sfr, mem_we, xdata_we, code_we, carry, insn_done, pc_reserved, unsupported_op;
    reg [7:0] rom [0:65535];
    reg [7:0] mem [0:511];
    reg [7:0] mm [0:511];
    wire [7:0] mem_rdata = mem[{mem_sfr, mem_addr}];
    exp_t eq[$];
    exp_t cur;
    logic [16:0] wq[$];
    logic [24:0] xq[$];
    integer mpc, mc, ma, cnt, i;
    integer checks = 0;
    integer num_errors = 0;
    reg [31:0] seed;
    reg saw_res;

    branch_bit_core #(.FLASH_64K(1)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .pc(pc), .code_b0(rom[pc]),
        .code_b1(rom[pc + 16'd1]), .code_b2(rom[pc + 16'd2]), .mem_addr(mem_addr),
        .mem_sfr(mem_sfr), .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .bank_select(2'b00), .data_pointer(data_pointer),
        .program_store_control(program_store_control), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .xdata_we(xdata_we), .code_we(code_we), .acc(acc),
        .carry(carry), .sp(sp), .insn_done(insn_done), .unsupported_op(unsupported_op),
        .pc_reserved(pc_reserved));

    function automatic [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction

    task check(input string name, input [24:0] exp, input [24:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task results;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Places one instruction at the model address and queues its outcome
    task automatic ins(input [7:0] b0, b1, b2, input integer len, cyc, tgt);
        rom[mpc] = b0;
        rom[mpc + 1] = b1;
        rom[mpc + 2] = b2;
        mpc = (tgt < 0) ? mpc + len : tgt;
        // Opcode 04 belongs to the arithmetic unit, so this core must flag it
        eq.push_back('{mpc[15:0], cyc, mc[0], ma[7:0], b0 == 8'h04});
    endtask

    task automatic bitop(input [7:0] op, input [7:0] ba);
        reg [8:0] bi;
        reg v;
        bi = ba[7] ? {1'b1, ba[7:3], 3'b000} : {1'b0, 8'h20 + {4'h0, ba[6:3]}};
        v = mm[bi][ba[2:0]];
        case (op)
            `OP_MOV_CB: mc = v;
            `OP_ANL_C: mc = mc & v;
            `OP_ANL_NC: mc = mc & !v;
            `OP_ORL_C: mc = mc | v;
            `OP_ORL_NC: mc = mc | !v;
            default: begin
                mm[bi][ba[2:0]] = (op == `OP_SETB_BIT) | (op == `OP_CPL_BIT & !v)
                    | (op == `OP_MOV_BC & mc[0]);
                wq.push_back({bi, mm[bi]});
            end
        endcase
        ins(op, ba, 8'h00, 2, 2, -1);
    endtask

    // ----
    // Clock, stimulus and monitor
    // ----
    initial begin
        forever #10 mclk = ~mclk;
    end

    // Write enable follows the code region so both write targets get exercised
    always @(posedge mclk) begin
        program_store_control <= {7'h00, pc[12]};
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            cnt = -1;
            saw_res = 1'b0;
        end else begin
            cnt = cnt + 1;
            if (pc_reserved) saw_res = 1'b1;
            if (insn_done && eq.size() > 0) begin
                cur = eq.pop_front();
                check("next address", cur.pc, pc);
                check("cycles", cur.cyc, cnt);
                check("carry", cur.c, carry);
                check("accumulator", cur.a, acc);
                check("unsupported flag", cur.u, unsupported_op);
                cnt = 0;
            end
            if (mem_we) begin
                check("data write", wq.pop_front(), {mem_sfr, mem_addr, mem_wdata});
                // Memory changes after the edge so the core never races its own read
                mem[{mem_sfr, mem_addr}] <= mem_wdata;
            end
            if (xdata_we || code_we) begin
                check("external write", xq.pop_front(), {code_we, ext_addr, ext_wdata});
            end
        end
    end

    initial begin
        repeat (5000) @(posedge mclk);
        num_errors = num_errors + 1;
        results();
    end

    initial begin
        seed = 32'd84606;
        for (i = 0; i < 65536; i = i + 1)
            rom[i] = 8'h00;
        for (i = 0; i < 512; i = i + 1) begin
            seed = xs(seed);
            mem[i] = seed[7:0];
        end
        // Keeps the accumulator nonzero after the exchange
        mem[255][0] = 1'b1;
        for (i = 0; i < 512; i = i + 1)
            mm[i] = mem[i];
        seed = xs(seed);
        data_pointer = {8'h06, seed[7:0]};
        mpc = 0;
        ma = 0;
        mc = 0;
        ins(`OP_CLR_C, 8'h00, 8'h00, 1, 1, -1);
        ins(`OP_JC, 8'h05, 8'h00, 2, 2, -1);
        mc = 1;
        ins(`OP_SETB_C, 8'h00, 8'h00, 1, 1, -1);
        ins(`OP_JC, 8'h7A, 8'h00, 2, 4, 'h80);
        mc = 0;
        ins(`OP_CPL_C, 8'h00, 8'h00, 1, 1, -1);
        ins(`OP_JNC, 8'h40, 8'h00, 2, 4, 'hC3);
        ins(`OP_SPARE, 8'h00, 8'h00, 1, 1, -1);
        ins(`OP_NOP, 8'h00, 8'h00, 1, 1, -1);
        bitop(`OP_SETB_BIT, 8'h13);
        bitop(`OP_CLR_BIT, 8'h8B);
        bitop(`OP_CPL_BIT, 8'h7F);
        bitop(`OP_MOV_CB, 8'h13);
        bitop(`OP_ANL_NC, 8'h00);
        bitop(`OP_ORL_C, 8'h01);
        bitop(`OP_ORL_NC, 8'h01);
        bitop(`OP_ANL_C, 8'h02);
        bitop(`OP_MOV_BC, 8'h05);
        ins(8'hD8, 8'h29, 8'h00, 2, 4, 'h102);
        wq.push_back({9'h0FF, ma[7:0]});
        i = ma;
        ma = mm[255];
        mm[255] = i[7:0];
        ins(8'hC6, 8'h00, 8'h00, 1, 2, -1);
        ins(`OP_JZ, 8'h10, 8'h00, 2, 2, -1);
        ins(`OP_JNZ, 8'h79, 8'h00, 2, 4, 'h180);
        ins(8'hA1, 8'h00, 8'h00, 2, 4, 'h500);
        ins(`OP_LJMP, 8'h12, 8'h00, 3, 5, 'h1200);
        xq.push_back({1'b1, data_pointer, ma[7:0]});
        ins(`OP_MOVX_DP, 8'h00, 8'h00, 1, 3, -1);
        ins(`OP_LJMP, 8'h02, 8'h00, 3, 5, 'h200);
        xq.push_back({1'b0, data_pointer, ma[7:0]});
        ins(`OP_MOVX_DP, 8'h00, 8'h00, 1, 3, -1);
        ins(`OP_SJMP, 8'hF0, 8'h00, 2, 4, 'h1F3);
        ins(`OP_JMP_IND, 8'h00, 8'h00, 1, 4, ma + data_pointer);
        // The call pushes into bank 1, which stays inside the core
        ins(8'hF1, 8'h80, 8'h00, 2, 4, 'h780);
        ins(8'h04, 8'h00, 8'h00, 1, 1, -1);
        mm[9'h022][3] = 1'b0;
        wq.push_back({9'h022, mm[9'h022]});
        ins(`OP_JBC, 8'h13, 8'h10, 3, 5, 'h794);
        ins(`OP_JNB, 8'h13, 8'h20, 3, 5, 'h7B7);
        seed = xs(seed);
        mc = ma < seed[7:0];
        i = (ma != seed[7:0]);
        ins(`OP_CJNE_AI, seed[7:0], 8'h08, 3, 3 + 2 * i, i ? 'h7C2 : -1);
        ins(`OP_LJMP, 8'hFC, 8'h00, 3, 5, 'hFC00);
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        for (i = 0; i < 2000 && eq.size() > 0; i = i + 1)
            @(posedge mclk);
        repeat (4) @(posedge mclk);
        check("pending results", 25'd0, eq.size());
        check("stack pointer", 25'h09, {17'd0, sp});
        check("reserved fetch flag", 25'd1, {24'd0, saw_res});
        results();
    end
endmodule

bind branch_bit_core branch_bit_core_properties chk (.mclk, .sys_rst, .clk_en, .pc, .code_b0,
    .code_b1, .code_b2, .mem_addr, .mem_sfr, .mem_we, .mem_wdata, .mem_rdata,
    .program_store_control, .xdata_we, .code_we, .carry, .insn_done);
